/* File: rtl/cmpd_map.svh */
// register map, field positions, mode codes and counts of the comparator block
`ifndef CMPD_MAP_SVH
`define CMPD_MAP_SVH
`define CMPD_IDX_CTRL  8'h97
`define CMPD_IDX_IEN   8'h98
`define CMPD_IDX_P3    8'h99
`define CMPD_ADDR_MIN  10
`define CMPD_B_IDLE    5
`define CMPD_B_FLAG    4
`define CMPD_B_EN      3
`define CMPD_F_MODE    2:0
`define CMPD_F_BYTE    7:0
`define CMPD_B_IRQEN   6
`define CMPD_B_CMP     6
`define CMPD_B_LANE0   0
`define CMPD_P3_RST    8'hFF
`define CMPD_MODE_LOW  3'h0
`define CMPD_MODE_RISE 3'h1
`define CMPD_MODE_DTOG 3'h2
`define CMPD_MODE_DRIS 3'h3
`define CMPD_MODE_FALL 3'h4
`define CMPD_MODE_TOG  3'h5
`define CMPD_MODE_DFAL 3'h6
`define CMPD_MODE_HIGH 3'h7
`define CMPD_DEB_OVF   2
`define CMPD_DEB_MAX   3
`endif

/* File: rtl/cmpd_pkg.sv */
// types and shared decoding of the comparator block
`default_nettype none
`include "cmpd_map.svh"
package cmpd_pkg;
  typedef logic [2:0] cmpd_mode_t;

  typedef enum logic [1:0] {DB_IDLE, DB_WAIT, DB_SAMPLE} cmpd_db_e;

  // register state of the top
  typedef struct packed {
    cmpd_mode_t  mode;
    logic        enable;
    logic        flag;
    logic        idle_run;
    logic        irq_en;
    logic [7:0]  p3_latch;
    logic        ack;
    logic [31:0] rdata;
    logic        irq;
    logic        wake;
  } cmpd_regs_s;

  typedef struct packed {
    logic res;
    logic prev;
  } cmpd_cmp_s;

  typedef struct packed {
    cmpd_db_e   st;
    logic       want;
    logic [1:0] cnt;
    logic       hit;
  } cmpd_db_s;

  // true for the three debounced mode codes
  function automatic logic cmpd_is_deb(input cmpd_mode_t m);
    return (m == `CMPD_MODE_DTOG) || (m == `CMPD_MODE_DRIS) ||
           (m == `CMPD_MODE_DFAL);
  endfunction
endpackage
`default_nettype wire

/* File: rtl/cmpd_evt_if.sv */
// event signals shared by the control core, front end and debouncer
`timescale 1ns/1ps
`default_nettype none
interface cmpd_evt_if;
  logic               active;
  cmpd_pkg::cmpd_mode_t mode;
  logic               result;
  logic               rise;
  logic               fall;
  logic               tmr_ovf;
  logic               deb_hit;
  modport front (input active, output result, rise, fall);
  modport deb   (input active, mode, result, rise, fall, tmr_ovf,
                 output deb_hit);
  modport core  (output active, mode, tmr_ovf,
                 input result, rise, fall, deb_hit);
endinterface
`default_nettype wire

/* File: rtl/cmpd_compare.sv */
// comparator front end: compare, gate by enable, edge detect
`timescale 1ns/1ps
`default_nettype none
module cmpd_compare #(
  parameter int IN_W = 8
) (
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  // sampled analog stage codes
  input  wire logic [IN_W-1:0] analog_in_pos,
  input  wire logic [IN_W-1:0] analog_in_neg,
  // event side
  cmpd_evt_if.front            evt
);
  cmpd_pkg::cmpd_cmp_s s_q;
  cmpd_pkg::cmpd_cmp_s s_d;

  if (IN_W < 1) begin : g_chk
    $error("cmpd_compare: IN_W must be at least 1");
  end

  // forced low while inactive, so only a falling edge can appear then
  always_comb begin
    s_d      = s_q;
    s_d.res  = evt.active && (analog_in_pos > analog_in_neg); // [R1] [R17]
    s_d.prev = s_q.res;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.result = s_q.res;
  assign evt.rise   = s_q.res && !s_q.prev;
  assign evt.fall   = !s_q.res && s_q.prev;

  property p_cmp_gt;
    @(posedge sys_clk) disable iff (!rst_b)
    (evt.active && (analog_in_pos > analog_in_neg)) |=> evt.result;
  endproperty
  a_cmp_gt: assert property (p_cmp_gt) // [R1]
    else $error("result not high with positive input above negative");
endmodule
`default_nettype wire

/* File: rtl/cmpd_debounce.sv */
// debouncer: resample after companion timer overflows
`timescale 1ns/1ps
`default_nettype none
`include "cmpd_map.svh"
module cmpd_debounce #(
  parameter int OVF_NEEDED = `CMPD_DEB_OVF
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // event side
  cmpd_evt_if.deb   evt
);
  localparam logic [1:0] OVF_LAST = 2'(OVF_NEEDED - 1);
  cmpd_pkg::cmpd_db_s s_q;
  cmpd_pkg::cmpd_db_s s_d;
  logic               trans;
  logic               exp_v;

  if (OVF_NEEDED < 1 || OVF_NEEDED > `CMPD_DEB_MAX) begin : g_chk
    $error("cmpd_debounce: OVF_NEEDED out of range");
  end

  // which transitions count in the selected mode
  always_comb begin
    trans = 1'b0;
    exp_v = evt.result;
    case (evt.mode)
      `CMPD_MODE_DTOG: trans = evt.rise || evt.fall;
      `CMPD_MODE_DRIS: trans = evt.rise;
      `CMPD_MODE_DFAL: trans = evt.fall;
      default:         trans = 1'b0;
    endcase
  end

  // the timer runs free, so the first overflow may come at once;
  // waiting for two bounds the delay between one and two periods
  always_comb begin
    s_d     = s_q;
    s_d.hit = 1'b0;
    if (!evt.active || !cmpd_pkg::cmpd_is_deb(evt.mode)) begin
      s_d.st  = cmpd_pkg::DB_IDLE;
      s_d.cnt = '0;
    end else if (trans) begin
      s_d.st     = cmpd_pkg::DB_WAIT; // [R11]
      s_d.want   = exp_v;
      s_d.cnt    = '0; // [R20]
    end else begin
      case (s_q.st)
        cmpd_pkg::DB_WAIT: begin
          if (evt.tmr_ovf) begin
            if (s_q.cnt == OVF_LAST) begin
              s_d.st = cmpd_pkg::DB_SAMPLE; // [R13]
            end else begin
              s_d.cnt = 2'(s_q.cnt + 2'h1);
            end
          end
        end
        cmpd_pkg::DB_SAMPLE: begin
          s_d.hit = (evt.result == s_q.want); // [R12]
          s_d.st  = cmpd_pkg::DB_IDLE;
        end
        default: s_d.st = cmpd_pkg::DB_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt.deb_hit = s_q.hit;

  property p_deb_restart;
    @(posedge sys_clk) disable iff (!rst_b)
    (evt.active && cmpd_pkg::cmpd_is_deb(evt.mode) && trans)
      |=> (s_q.st == cmpd_pkg::DB_WAIT) && (s_q.cnt == 2'h0);
  endproperty
  a_deb_restart: assert property (p_deb_restart) // [R20]
    else $error("debounce did not restart on a transition");

  // a mode write during the sample cycle drops the sample on purpose
  property p_deb_match;
    @(posedge sys_clk) disable iff (!rst_b)
    (evt.active && cmpd_pkg::cmpd_is_deb(evt.mode) && !trans &&
     s_q.st == cmpd_pkg::DB_SAMPLE)
      |=> (evt.deb_hit == $past(evt.result == s_q.want));
  endproperty
  a_deb_match: assert property (p_deb_match) // [R12]
    else $error("debounce hit does not follow resample");
endmodule
`default_nettype wire

/* File: rtl/cmpd_top.sv */
// comparator event and debounce logic with its register slave
//
// Overview of operation
// [R1] result is one only when positive input exceeds negative input
// [R2] software ignores output and flag 10 us after enabling
// [R3] software clears the flag before enabling the interrupt
// [R4] software sets both analog pins input only before enabling
// [R5] port 3 pin reads return the live result on bit 6
// [R6] port 3 bit 6 writes change only the latch, not the comparator
// [R7] flag sets when the result meets the selected mode condition
// [R8] hardware never clears the flag; only a software write does
// [R9] flag raises an interrupt only while the irq enable bit is set
// [R10] outside debounce modes the result is sampled every cycle
// [R11] debounce modes wait two timer overflows before resampling
// [R12] debounced flag sets only when resample equals expected value
// [R13] debounced event is flagged one to two timer periods later
// [R14] idle stops the comparator unless idle run is set; may wake
// [R15] power-down always stops the comparator
// [R16] control register at 97H: idle 5, flag 4, enable 3, mode 2:0
// [R17] with enable clear the result is low and no event sets flag
// [R18] mode codes: low, rise, dtoggle, drise, fall, toggle, dfall, high
// [R19] level modes set the flag every cycle the level is present
// [R20] each relevant transition restarts the overflow count
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "cmpd_map.svh"
module cmpd_top #(
  parameter int ADDR_W     = 10,
  parameter int IN_W       = 8,
  parameter int OVF_NEEDED = `CMPD_DEB_OVF
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // analog stage codes
  input  wire logic [IN_W-1:0]   analog_in_pos,
  input  wire logic [IN_W-1:0]   analog_in_neg,
  // companion timer and power state
  input  wire logic              timer1_overflow,
  input  wire logic              idle_mode,
  input  wire logic              power_down_mode,
  // port 3 pins and latch
  input  wire logic [7:0]        port3_pins,
  output logic [7:0]             port3_latch,
  // results
  output logic                   comparator_out,
  output logic                   irq_req,
  output logic                   wake_req
);
  cmpd_pkg::cmpd_regs_s r_q;
  cmpd_pkg::cmpd_regs_s r_d;
  cmpd_evt_if           evt ();
  logic                 req;
  logic                 wr_go;
  logic                 wr_ctrl;
  logic                 wr_ien;
  logic                 wr_p3;
  logic                 rd_first;
  logic                 set_evt;
  logic [31:0]          rd_mux;

  if (ADDR_W < `CMPD_ADDR_MIN) begin : g_chk
    $error("cmpd_top: ADDR_W too small for the register map");
  end

  // true when the address is the byte address of a register index (index times four)
  function automatic logic reg_sel(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  // front end and debouncer share the event interface
  cmpd_compare #(
    .IN_W          (IN_W)
  ) u_cmp (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .analog_in_pos (analog_in_pos),
    .analog_in_neg (analog_in_neg),
    .evt           (evt)
  );

  cmpd_debounce #(
    .OVF_NEEDED    (OVF_NEEDED)
  ) u_deb (
    .sys_clk       (sys_clk),
    .rst_b         (rst_b),
    .evt           (evt)
  );

  // comparator runs only when enabled and the power state allows it
  assign evt.active  = r_q.enable && !power_down_mode &&  // [R15] [R17]
                       (!idle_mode || r_q.idle_run);     // [R14]
  assign evt.mode    = r_q.mode;
  assign evt.tmr_ovf = timer1_overflow;

  // one wait cycle: read data are captured, then the answer stands
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !r_q.ack;
  assign wr_go           = avs_write && r_q.ack &&
                           avs_byteenable[`CMPD_B_LANE0];
  assign wr_ctrl         = wr_go && reg_sel(avs_address, `CMPD_IDX_CTRL);
  assign wr_ien          = wr_go && reg_sel(avs_address, `CMPD_IDX_IEN);
  assign wr_p3           = wr_go && reg_sel(avs_address, `CMPD_IDX_P3);
  assign rd_first        = avs_read && !r_q.ack;

  // read multiplexer; unmapped words and reserved bits read zero
  always_comb begin
    rd_mux = '0;
    if (reg_sel(avs_address, `CMPD_IDX_CTRL)) begin
      rd_mux[`CMPD_B_IDLE] = r_q.idle_run; // [R16]
      rd_mux[`CMPD_B_FLAG] = r_q.flag; // [R8]
      rd_mux[`CMPD_B_EN]   = r_q.enable;
      rd_mux[`CMPD_F_MODE] = r_q.mode;
    end else if (reg_sel(avs_address, `CMPD_IDX_IEN)) begin
      rd_mux[`CMPD_B_IRQEN] = r_q.irq_en;
    end else if (reg_sel(avs_address, `CMPD_IDX_P3)) begin
      rd_mux[`CMPD_F_BYTE] = port3_pins;
      rd_mux[`CMPD_B_CMP]  = evt.result; // [R5]
    end
  end

  // event condition per mode; level modes fire every sampled cycle
  always_comb begin
    set_evt = 1'b0;
    case (r_q.mode) // [R18]
      `CMPD_MODE_LOW:  set_evt = !evt.result; // [R19]
      `CMPD_MODE_HIGH: set_evt = evt.result; // [R19]
      `CMPD_MODE_RISE: set_evt = evt.rise; // [R10]
      `CMPD_MODE_FALL: set_evt = evt.fall; // [R10]
      `CMPD_MODE_TOG:  set_evt = evt.rise || evt.fall; // [R10]
      default:         set_evt = evt.deb_hit; // [R12]
    endcase
    set_evt = set_evt && evt.active; // [R17]
  end

  // next register state
  always_comb begin
    r_d     = r_q;
    r_d.ack = req && !r_q.ack;
    if (rd_first) begin
      r_d.rdata = rd_mux;
    end
    if (wr_ctrl) begin
      r_d.idle_run = avs_writedata[`CMPD_B_IDLE];
      r_d.flag     = avs_writedata[`CMPD_B_FLAG]; // [R8]
      r_d.enable   = avs_writedata[`CMPD_B_EN];
      r_d.mode     = avs_writedata[`CMPD_F_MODE];
    end
    if (wr_ien) begin
      r_d.irq_en = avs_writedata[`CMPD_B_IRQEN];
    end
    // the port write leaves comparator state alone
    if (wr_p3) begin
      r_d.p3_latch = avs_writedata[`CMPD_F_BYTE]; // [R6]
    end
    // set beats a clear written in the same cycle
    if (set_evt) begin
      r_d.flag = 1'b1; // [R7]
    end
    r_d.irq  = r_d.flag && r_d.irq_en; // [R9]
    r_d.wake = r_d.irq && idle_mode && r_d.idle_run; // [R14]
  end

  // low six control bits clear; port latch comes up all ones
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q          <= '0; // [R16]
      r_q.p3_latch <= `CMPD_P3_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from flops
  assign avs_readdata   = r_q.rdata;
  assign port3_latch    = r_q.p3_latch;
  assign comparator_out = evt.result;
  assign irq_req        = r_q.irq;
  assign wake_req       = r_q.wake;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_flag_sticky;
    (r_q.flag && !wr_ctrl) |=> r_q.flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // [R8]
    else $error("flag cleared without a software write");

  property p_irq_gate;
    irq_req == (r_q.flag && r_q.irq_en);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [R9]
    else $error("interrupt not gated by flag and enable");

  property p_low_level;
    (evt.active && r_q.mode == `CMPD_MODE_LOW && !evt.result)
      ##1 !r_q.flag ##0 (r_q.mode == `CMPD_MODE_LOW) |-> 1'b0;
  endproperty
  a_low_level: assert property (p_low_level) // [R19]
    else $error("low level did not hold the flag set");

  property p_disabled;
    !r_q.enable |=> !evt.result;
  endproperty
  a_disabled: assert property (p_disabled) // [R17]
    else $error("result not forced low while disabled");

  property p_pd_off;
    power_down_mode |-> !evt.active;
  endproperty
  a_pd_off: assert property (p_pd_off) // [R15]
    else $error("comparator active in power-down");

  property p_idle_off;
    (idle_mode && !r_q.idle_run) |-> !evt.active ##1 !evt.result;
  endproperty
  a_idle_off: assert property (p_idle_off) // [R14]
    else $error("comparator active in idle without idle run");

  property p_p3_mirror;
    (rd_first && reg_sel(avs_address, `CMPD_IDX_P3))
      |=> avs_readdata[`CMPD_B_CMP] == $past(evt.result);
  endproperty
  a_p3_mirror: assert property (p_p3_mirror) // [R5]
    else $error("port read does not mirror the result");

  property p_p3_write;
    wr_p3 |=> (port3_latch == $past(avs_writedata[`CMPD_F_BYTE])) &&
              (r_q.enable == $past(r_q.enable));
  endproperty
  a_p3_write: assert property (p_p3_write) // [R6]
    else $error("port write wrong or touched the comparator");

  property p_edge_sample;
    (evt.active && r_q.mode == `CMPD_MODE_RISE && evt.rise)
      |=> r_q.flag ##1 r_q.flag || $past(wr_ctrl);
  endproperty
  a_edge_sample: assert property (p_edge_sample) // [R10]
    else $error("rising edge missed by the flag");
endmodule
`default_nettype wire

/* File: test/cmpd_analog_model.sv */
// analog stage and free-running companion timer model
`timescale 1ns/1ps
`default_nettype none
module cmpd_analog_model #(
  parameter int PER = 20
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // requested relation: 0 below, 1 above, 2 equal
  input  wire logic [1:0] sel,
  input  wire logic       tmr_run,
  // to the block
  output logic [7:0]      pos,
  output logic [7:0]      neg,
  output logic            ovf
);
  int cnt;
  // codes one step around a midpoint; equal is the awkward case
  // pins kept input only, so nothing but the source sets the codes
  assign neg = 8'h80;
  assign pos = (sel == 2'h1) ? 8'h81 : (sel == 2'h2) ? 8'h80 : 8'h7F;
  // timer runs free, so an edge lands anywhere inside a period
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      ovf <= 1'b0;
    end else begin
      cnt <= (!tmr_run || cnt == PER - 1) ? 0 : cnt + 1;
      ovf <= tmr_run && (cnt == PER - 1);
    end
  end
endmodule
`default_nettype wire

/* File: test/cmpd_top_test.sv */
// self-checking bench of the comparator event and debounce block
`timescale 1ns/1ps
`default_nettype none
`include "cmpd_map.svh"
module cmpd_top_test;
  localparam int PER = 20;
  // bench-driven inputs
  logic        sys_clk         = 1'b0;
  logic        rst_b           = 1'b0;
  logic [9:0]  avs_address     = 10'h000;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h00000000;
  logic [3:0]  avs_byteenable  = 4'hF;
  logic [1:0]  sel             = 2'h0;
  logic        tmr_run         = 1'b0;
  logic        idle_mode       = 1'b0;
  logic        power_down_mode = 1'b0;
  logic [7:0]  port3_pins      = 8'hA5;
  // observed outputs
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  pos;
  logic [7:0]  neg;
  logic        ovf;
  logic [7:0]  port3_latch;
  logic        comparator_out;
  logic        irq_req;
  logic        wake_req;
  int          err_count       = 0;
  int          n_tests         = 0;

  // 100 ns period
  always #50 sys_clk = ~sys_clk;

  cmpd_top #(.ADDR_W(10), .IN_W(8), .OVF_NEEDED(2)) u_cmpd_top (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .analog_in_pos(pos), .analog_in_neg(neg), .timer1_overflow(ovf),
    .idle_mode(idle_mode), .power_down_mode(power_down_mode),
    .port3_pins(port3_pins), .port3_latch(port3_latch),
    .comparator_out(comparator_out), .irq_req(irq_req),
    .wake_req(wake_req));

  cmpd_analog_model #(.PER(PER)) u_cmpd_analog_model (
    .sys_clk(sys_clk), .rst_b(rst_b), .sel(sel), .tmr_run(tmr_run),
    .pos(pos), .neg(neg), .ovf(ovf));

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // compare one value
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr_n, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_write <= wr_n;
    avs_read <= !wr_n;
    // looked at on the edge itself, before the design's flops move
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      results();
    end
  endtask

  // register helpers
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    bus(1'b1, idx, d, v);
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx,
                      input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    chk(nm, v, exp);
  endtask

  // waits leave us mid-cycle; every drive waits for a rising edge first
  task automatic nap(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic setsel(input logic [1:0] v);
    @(posedge sys_clk);
    sel <= v;
  endtask

  // reset values, an unmapped place and a write on a disabled lane
  task automatic t_reset();
    rchk("ctrl_rst", `CMPD_IDX_CTRL, 8'h00);
    chk("latch_rst", port3_latch, `CMPD_P3_RST);
    wr(8'h10, 8'h3F);
    rchk("unmapped", 8'h10, 8'h00);
    // lane 0 off: the control write must be ignored
    @(posedge sys_clk) avs_byteenable <= 4'hE;
    wr(`CMPD_IDX_CTRL, 8'h3F);
    rchk("lane_off", `CMPD_IDX_CTRL, 8'h00);
    @(posedge sys_clk) avs_byteenable <= 4'hF;
    rchk("ctrl_keep", `CMPD_IDX_CTRL, 8'h00);
  endtask

  // compare, gating and port 3 read path
  task automatic t_compare();
    setsel(2'h1);
    wr(`CMPD_IDX_CTRL, {5'h00, `CMPD_MODE_HIGH});
    nap(4);
    chk("out_off", {7'h00, comparator_out}, 8'h00);
    rchk("flag_off", `CMPD_IDX_CTRL, {5'h00, `CMPD_MODE_HIGH});
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_HIGH});
    nap(100);
    chk("out_above", {7'h00, comparator_out}, 8'h01);
    rchk("p3_above", `CMPD_IDX_P3, 8'hE5);
    setsel(2'h2);
    nap(3);
    chk("out_equal", {7'h00, comparator_out}, 8'h00);
    rchk("p3_equal", `CMPD_IDX_P3, 8'hA5);
    wr(`CMPD_IDX_P3, 8'h00);
    nap(2);
    chk("latch_wr", port3_latch, 8'h00);
    setsel(2'h1);
    nap(3);
    chk("out_kept", {7'h00, comparator_out}, 8'h01);
  endtask

  // flag, interrupt gating and level modes
  task automatic t_level();
    setsel(2'h0);
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_RISE});
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_RISE});
    wr(`CMPD_IDX_IEN, 8'h40);
    nap(3);
    chk("irq_quiet", {7'h00, irq_req}, 8'h00);
    setsel(2'h1);
    nap(4);
    chk("irq_on", {7'h00, irq_req}, 8'h01);
    nap(50);
    rchk("flag_kept", `CMPD_IDX_CTRL, {5'h03, `CMPD_MODE_RISE});
    wr(`CMPD_IDX_IEN, 8'h00);
    nap(3);
    chk("irq_masked", {7'h00, irq_req}, 8'h00);
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_RISE});
    rchk("flag_clr", `CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_RISE});
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_HIGH});
    rchk("high_again", `CMPD_IDX_CTRL, {5'h03, `CMPD_MODE_HIGH});
    setsel(2'h0);
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_LOW});
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_LOW});
    rchk("low_again", `CMPD_IDX_CTRL, {5'h03, `CMPD_MODE_LOW});
  endtask

  // edge modes catch a one-cycle pulse
  task automatic t_edges();
    logic [2:0] m[3];
    logic [1:0] f[3];
    m = '{`CMPD_MODE_RISE, `CMPD_MODE_FALL, `CMPD_MODE_TOG};
    f = '{2'h0, 2'h1, 2'h0};
    for (int i = 0; i < 3; i++) begin
      setsel(f[i]);
      wr(`CMPD_IDX_CTRL, {5'h01, m[i]});
      wr(`CMPD_IDX_CTRL, {5'h01, m[i]});
      rchk("edge_quiet", `CMPD_IDX_CTRL, {5'h01, m[i]});
      setsel({1'b0, ~f[i][0]});
      setsel(f[i]);
      rchk("edge_hit", `CMPD_IDX_CTRL, {5'h03, m[i]});
    end
  endtask

  // debounced modes: latency window, then a rejected glitch
  task automatic t_deb();
    logic [2:0] m[3];
    logic [1:0] f[3];
    int n;
    m = '{`CMPD_MODE_DRIS, `CMPD_MODE_DFAL, `CMPD_MODE_DTOG};
    f = '{2'h0, 2'h1, 2'h1};
    @(posedge sys_clk) tmr_run <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      setsel(f[i]);
      wr(`CMPD_IDX_CTRL, {5'h01, m[i]});
      nap(3 * PER);
      wr(`CMPD_IDX_CTRL, {5'h01, m[i]});
      wr(`CMPD_IDX_IEN, 8'h40);
      setsel({1'b0, ~f[i][0]});
      n = 0;
      while (irq_req !== 1'b1 && n < 3 * PER) begin
        @(negedge sys_clk);
        n++;
      end
      chk("deb_delay", 8'((n >= PER) && (n <= 2 * PER + 8)), 8'h01);
      // a wait that ran out has been counted; stop here
      if (n >= 3 * PER) begin
        results();
      end
    end
    setsel(2'h0);
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_DRIS});
    nap(3 * PER);
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_DRIS});
    setsel(2'h1);
    setsel(2'h0);
    nap(3 * PER);
    chk("deb_drop", {7'h00, irq_req}, 8'h00);
  endtask

  // idle and power-down gating
  task automatic t_power();
    setsel(2'h1);
    @(posedge sys_clk) idle_mode <= 1'b1;
    wr(`CMPD_IDX_CTRL, {5'h01, `CMPD_MODE_HIGH});
    nap(4);
    chk("idle_off", {7'h00, irq_req}, 8'h00);
    wr(`CMPD_IDX_CTRL, {5'h05, `CMPD_MODE_HIGH});
    nap(4);
    chk("idle_wake", {7'h00, wake_req}, 8'h01);
    rchk("idle_rd", `CMPD_IDX_CTRL, 8'h3F);
    @(posedge sys_clk) power_down_mode <= 1'b1;
    nap(4);
    wr(`CMPD_IDX_CTRL, {5'h05, `CMPD_MODE_HIGH});
    nap(4);
    chk("pd_off", {7'h00, irq_req}, 8'h00);
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_compare();
    t_level();
    t_edges();
    t_deb();
    t_power();
    results();
  end
endmodule
`default_nettype wire
